/* verilog/acmc_params.svh */
// Command words, frame lengths and wake-up timing for the mode controller
`ifndef ACMC_PARAMS_SVH
`define ACMC_PARAMS_SVH

`define ACMC_CMD_CONTINUE 16'h0000
`define ACMC_CMD_LIGHT_SLEEP 16'h8200
`define ACMC_CMD_DEEP_SLEEP 16'h8300
`define ACMC_CMD_DEFAULTS 16'h8500
`define ACMC_CMD_AUTO_SCAN 16'hA000
`define ACMC_CMD_FIXED_BASE 16'hC000
`define ACMC_CMD_AUX_SELECT 16'hE000

`define ACMC_FIXED_TAG_MSB 15
`define ACMC_FIXED_TAG_LSB 13
`define ACMC_FIXED_TAG 3'h6
`define ACMC_FIXED_CH_MSB 12
`define ACMC_FIXED_CH_LSB 10
`define ACMC_FIXED_LOW_MSB 9

`define ACMC_CMD_BITS 16
`define ACMC_FULL_FRAME_CLOCKS 32

`define ACMC_CLK_PERIOD_NS 20
`define ACMC_WAKE_LIGHT_NS 20000
`define ACMC_WAKE_DEEP_NS 15000000

`endif

/* verilog/acmc_pkg.sv */
// Types shared by the mode controller modules
package acmc_pkg;
    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_INVALID,
        MODE_LIGHT_SLEEP,
        MODE_DEEP_SLEEP,
        MODE_DEFAULTS,
        MODE_AUTO_SCAN,
        MODE_FIXED_CHANNEL
    } acmc_mode_e;

    typedef logic [2:0] acmc_chan_t;
    typedef logic [5:0] acmc_count_t;
endpackage

/* verilog/acmc_frame_if.sv */
// Frame events passed from the serial receiver to the mode controller
`timescale 1ns/1ps
interface acmc_frame_if;
    logic frameStart;
    logic frameDone;
    logic frameAbort;
    logic [15:0] word;
    acmc_pkg::acmc_count_t edgeCount;

    modport rx
    (
        output frameStart,
        output frameDone,
        output frameAbort,
        output word,
        output edgeCount
    );
    modport ctl
    (
        input frameStart,
        input frameDone,
        input frameAbort,
        input word,
        input edgeCount
    );
endinterface

/* verilog/acmc_frame_rx.sv */
// Serial command receiver: synchronises the pins and frames the command word
`timescale 1ns/1ps
`include "acmc_params.svh"
module acmc_frame_rx
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    acmc_frame_if.rx link
);
    import acmc_pkg::*;

    logic csMeta, csSync, csPrev;
    logic sclkMeta, sclkSync, sclkPrev;
    logic sdiMeta, sdiSync;
    logic [15:0] shiftReg;
    acmc_count_t edges;
    wire logic csFall = csPrev & ~csSync;
    wire logic csRise = ~csPrev & csSync;
    wire logic sclkFall = sclkPrev & ~sclkSync & ~csSync;
    wire logic takeBit = sclkFall && (edges < acmc_count_t'(`ACMC_CMD_BITS));
    wire logic wholeWord = (edges >= acmc_count_t'(`ACMC_CMD_BITS));

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            csMeta <= 1'b1;
            csSync <= 1'b1;
            csPrev <= 1'b1;
            sclkMeta <= 1'b0;
            sclkSync <= 1'b0;
            sclkPrev <= 1'b0;
            sdiMeta <= 1'b0;
            sdiSync <= 1'b0;
        end
        else
        begin
            csMeta <= csN;
            csSync <= csMeta;
            csPrev <= csSync;
            sclkMeta <= sclk;
            sclkSync <= sclkMeta;
            sclkPrev <= sclkSync;
            sdiMeta <= sdi;
            sdiSync <= sdiMeta;
        end
    end

    // ----------------------------------------
    // Framing
    // ----------------------------------------
    // Bits after the sixteenth are ignored; edges still count to spot full frames
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            shiftReg <= 16'h0000;
            edges <= 6'h00;
            link.frameStart <= 1'b0;
            link.frameDone <= 1'b0;
            link.frameAbort <= 1'b0;
            link.word <= 16'h0000;
            link.edgeCount <= 6'h00;
        end
        else
        begin
            link.frameStart <= csFall;
            link.frameDone <= csRise && wholeWord;
            link.frameAbort <= csRise && !wholeWord;
            if (csFall)
            begin
                edges <= 6'h00;
                shiftReg <= 16'h0000;
            end
            else if (sclkFall && edges != 6'h3F)
            begin
                edges <= edges + 6'h01;
            end
            if (takeBit)
            begin
                shiftReg <= {shiftReg[14:0], sdiSync};
            end
            if (csRise)
            begin
                link.word <= shiftReg;
                link.edgeCount <= edges;
            end
        end
    end

    property p_short_frame_aborts;
        @(posedge clk) disable iff (!resetn)
        (csRise && edges < 6'h10) |=> link.frameAbort && !link.frameDone;
    endproperty
    a_short_frame_aborts: assert property (p_short_frame_aborts)
        else $error("short frame did not abort");

    property p_word_needs_sixteen;
        @(posedge clk) disable iff (!resetn)
        link.frameDone |-> link.edgeCount >= 6'h10;
    endproperty
    a_word_needs_sixteen: assert property (p_word_needs_sixteen)
        else $error("command acted on before sixteen edges");
endmodule

/* verilog/acmc_scan_step.sv */
// Auto-scan sequence helper: lowest enabled channel and the one after the current
`timescale 1ns/1ps
module acmc_scan_step
#(
    parameter int CHANNELS = 8
)
(
    input wire logic [CHANNELS-1:0] enables,
    input wire acmc_pkg::acmc_chan_t current,
    output acmc_pkg::acmc_chan_t lowest,
    output acmc_pkg::acmc_chan_t following
);
    import acmc_pkg::*;

    initial
    begin
        if (CHANNELS < 1 || CHANNELS > 8)
        begin
            $error("CHANNELS must be 1 to 8");
        end
    end

    // Empty mask falls back to channel zero
    always_comb
    begin
        lowest = 3'h0;
        for (int i = CHANNELS - 1; i >= 0; i--)
        begin
            if (enables[i])
            begin
                lowest = acmc_chan_t'(i);
            end
        end
    end

    always_comb
    begin
        following = lowest;
        for (int i = CHANNELS - 1; i >= 0; i--)
        begin
            if (enables[i] && acmc_chan_t'(i) > current)
            begin
                following = acmc_chan_t'(i);
            end
        end
    end
endmodule

/* verilog/acmc_mode_ctrl.sv */
// Operating-mode controller for the serial command port of a multichannel converter
`timescale 1ns/1ps
`include "acmc_params.svh"

module acmc_mode_ctrl
#(
    parameter int CHANNELS = 8,
    parameter int DEEP_WAKE_CYCLES = `ACMC_WAKE_DEEP_NS / `ACMC_CLK_PERIOD_NS
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic [CHANNELS-1:0] sequenceEnables,
    input wire logic settingsAccessState,
    input wire logic referenceSourceChoice,
    output acmc_pkg::acmc_mode_e mode,
    output logic sampleStrobe,
    output acmc_pkg::acmc_chan_t sampleChannel,
    output logic sampleAux,
    output acmc_pkg::acmc_chan_t alarmChannel,
    output logic alarmAux,
    output logic dataInvalid,
    output logic referencePowerOn,
    output logic corePowerOn,
    output logic [CHANNELS-1:0] channelPowerOn,
    output logic loadDefaults,
    output logic settingsAbandon,
    output logic analogReady
);
    import acmc_pkg::*;

    localparam int LIGHT_WAKE_CYCLES = `ACMC_WAKE_LIGHT_NS / `ACMC_CLK_PERIOD_NS;
    localparam int WAKE_BITS = 20;

    initial
    begin
        if (DEEP_WAKE_CYCLES < 1 || DEEP_WAKE_CYCLES >= (1 << WAKE_BITS))
        begin
            $error("DEEP_WAKE_CYCLES out of range");
        end
        if (CHANNELS < 1 || CHANNELS > 8)
        begin
            $error("CHANNELS must be 1 to 8");
        end
    end

    // ----------------------------------------
    // Command decoding
    // ----------------------------------------
    function automatic logic isFixedWord(input logic [15:0] w);
        return w[`ACMC_FIXED_TAG_MSB:`ACMC_FIXED_TAG_LSB] == `ACMC_FIXED_TAG
            && w[`ACMC_FIXED_LOW_MSB:0] == 10'h000;
    endfunction

    function automatic logic isConverting(input acmc_mode_e m);
        return m == MODE_AUTO_SCAN || m == MODE_FIXED_CHANNEL;
    endfunction

    function automatic logic isSleeping(input acmc_mode_e m);
        return m == MODE_LIGHT_SLEEP || m == MODE_DEEP_SLEEP;
    endfunction

    acmc_frame_if frame ();

    acmc_frame_rx u_rx
    (
        .clk(clk),
        .resetn(resetn),
        .csN(csN),
        .sclk(sclk),
        .sdi(sdi),
        .link(frame.rx)
    );

    acmc_mode_e next_mode;
    acmc_chan_t scanPos;
    acmc_chan_t fixedChannel;
    logic fixedAux;
    acmc_chan_t lowestCh;
    acmc_chan_t followingCh;
    logic [WAKE_BITS-1:0] wakeCount;
    logic [WAKE_BITS-1:0] next_wakeCount;

    wire logic [15:0] cmd = frame.word;
    wire logic done = frame.frameDone;
    wire logic cmdContinue = done && cmd == `ACMC_CMD_CONTINUE;
    wire logic cmdLight = done && cmd == `ACMC_CMD_LIGHT_SLEEP;
    wire logic cmdDeep = done && cmd == `ACMC_CMD_DEEP_SLEEP;
    wire logic cmdDefaults = done && cmd == `ACMC_CMD_DEFAULTS;
    wire logic cmdAuto = done && cmd == `ACMC_CMD_AUTO_SCAN;
    wire logic cmdFixed = done && isFixedWord(cmd);
    wire logic cmdAux = done && cmd == `ACMC_CMD_AUX_SELECT;
    wire acmc_chan_t cmdChannel = cmd[`ACMC_FIXED_CH_MSB:`ACMC_FIXED_CH_LSB];
    wire logic sampleNow = frame.frameStart && isConverting(mode);
    wire logic [CHANNELS-1:0] allChannels = {CHANNELS{1'b1}};

    acmc_scan_step #(.CHANNELS(CHANNELS)) u_step
    (
        .enables(sequenceEnables),
        .current(scanPos),
        .lowest(lowestCh),
        .following(followingCh)
    );

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    // Words that match no command are settings accesses and leave the mode alone
    always_comb
    begin
        next_mode = mode;
        if (frame.frameAbort)
        begin
            next_mode = MODE_INVALID;
        end
        else if (cmdContinue && settingsAccessState)
        begin
            next_mode = MODE_IDLE;
        end
        else if (cmdLight)
        begin
            next_mode = MODE_LIGHT_SLEEP;
        end
        else if (cmdDeep)
        begin
            next_mode = MODE_DEEP_SLEEP;
        end
        else if (cmdDefaults)
        begin
            next_mode = MODE_DEFAULTS;
        end
        else if (cmdAuto)
        begin
            next_mode = MODE_AUTO_SCAN;
        end
        else if (cmdFixed || cmdAux)
        begin
            next_mode = MODE_FIXED_CHANNEL;
        end
    end

    // ----------------------------------------
    // Wake-up timing
    // ----------------------------------------
    // Reference only needs the long settle when it is the internal one
    always_comb
    begin
        next_wakeCount = wakeCount;
        if (isSleeping(mode) && !isSleeping(next_mode))
        begin
            if (mode == MODE_DEEP_SLEEP && !referenceSourceChoice)
            begin
                next_wakeCount = WAKE_BITS'(DEEP_WAKE_CYCLES);
            end
            else
            begin
                next_wakeCount = WAKE_BITS'(LIGHT_WAKE_CYCLES);
            end
        end
        else if (wakeCount != '0)
        begin
            next_wakeCount = wakeCount - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            mode <= MODE_IDLE;
            wakeCount <= '0;
            analogReady <= 1'b0;
            referencePowerOn <= 1'b1;
            corePowerOn <= 1'b1;
            channelPowerOn <= '0;
        end
        else
        begin
            mode <= next_mode;
            wakeCount <= next_wakeCount;
            analogReady <= next_wakeCount == '0 && isConverting(next_mode);
            referencePowerOn <= next_mode != MODE_DEEP_SLEEP;
            corePowerOn <= !isSleeping(next_mode);
            if (next_mode == MODE_AUTO_SCAN)
            begin
                channelPowerOn <= sequenceEnables;
            end
            else if (next_mode == MODE_FIXED_CHANNEL)
            begin
                channelPowerOn <= allChannels;
            end
            else
            begin
                channelPowerOn <= '0;
            end
        end
    end

    // ----------------------------------------
    // Channel selection and sampling
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            scanPos <= 3'h0;
            fixedChannel <= 3'h0;
            fixedAux <= 1'b0;
        end
        else if (cmdAuto)
        begin
            scanPos <= lowestCh;
        end
        else if (cmdFixed || cmdAux)
        begin
            fixedChannel <= cmdAux ? 3'h0 : cmdChannel;
            fixedAux <= cmdAux;
        end
        else if (sampleNow && mode == MODE_AUTO_SCAN)
        begin
            scanPos <= followingCh;
        end
    end

    // Alarm follows the last sampled input, so abort and sleep leave it alone
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sampleStrobe <= 1'b0;
            sampleChannel <= 3'h0;
            sampleAux <= 1'b0;
            alarmChannel <= 3'h0;
            alarmAux <= 1'b0;
        end
        else
        begin
            sampleStrobe <= sampleNow;
            if (sampleNow)
            begin
                sampleChannel <= mode == MODE_AUTO_SCAN ? scanPos : fixedChannel;
                sampleAux <= mode == MODE_FIXED_CHANNEL && fixedAux;
                alarmChannel <= mode == MODE_AUTO_SCAN ? scanPos : fixedChannel;
                alarmAux <= mode == MODE_FIXED_CHANNEL && fixedAux;
            end
        end
    end

    // ----------------------------------------
    // Frame data validity and settings effects
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            dataInvalid <= 1'b1;
            loadDefaults <= 1'b0;
            settingsAbandon <= 1'b0;
        end
        else
        begin
            if (frame.frameAbort)
            begin
                dataInvalid <= 1'b1;
            end
            else if (frame.frameStart)
            begin
                dataInvalid <= !isConverting(mode);
            end
            loadDefaults <= cmdDefaults;
            settingsAbandon <= cmdContinue && settingsAccessState;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_zero_keeps_mode;
        @(posedge clk) disable iff (!resetn)
        (cmdContinue && !settingsAccessState) |=> mode == $past(mode) && !loadDefaults;
    endproperty
    a_zero_keeps_mode: assert property (p_zero_keeps_mode)
        else $error("zero word changed the mode");

    property p_zero_access_idle;
        @(posedge clk) disable iff (!resetn)
        (cmdContinue && settingsAccessState) |=> mode == MODE_IDLE && settingsAbandon;
    endproperty
    a_zero_access_idle: assert property (p_zero_access_idle)
        else $error("zero word during access did not go idle");

    property p_abort_invalid;
        @(posedge clk) disable iff (!resetn)
        frame.frameAbort |=> mode == MODE_INVALID && dataInvalid;
    endproperty
    a_abort_invalid: assert property (p_abort_invalid)
        else $error("aborted frame not invalid");

    property p_invalid_alarm_holds;
        @(posedge clk) disable iff (!resetn)
        (mode == MODE_INVALID && $past(mode) == MODE_INVALID) |-> $stable(alarmChannel);
    endproperty
    a_invalid_alarm_holds: assert property (p_invalid_alarm_holds)
        else $error("alarm channel moved in invalid state");

    property p_light_entry;
        @(posedge clk) disable iff (!resetn)
        cmdLight |=> mode == MODE_LIGHT_SLEEP && referencePowerOn && !corePowerOn;
    endproperty
    a_light_entry: assert property (p_light_entry)
        else $error("light sleep entry wrong");

    property p_deep_entry;
        @(posedge clk) disable iff (!resetn)
        cmdDeep |=> mode == MODE_DEEP_SLEEP && !referencePowerOn && !corePowerOn;
    endproperty
    a_deep_entry: assert property (p_deep_entry)
        else $error("deep sleep entry wrong");

    property p_light_wake_time;
        @(posedge clk) disable iff (!resetn)
        (mode == MODE_LIGHT_SLEEP && (cmdAuto || cmdFixed || cmdAux)) |=> wakeCount == 20'h003E8;
    endproperty
    a_light_wake_time: assert property (p_light_wake_time)
        else $error("light sleep wake count wrong");

    property p_sleep_frame_invalid;
        @(posedge clk) disable iff (!resetn)
        (frame.frameStart && isSleeping(mode)) |=> dataInvalid && !sampleStrobe;
    endproperty
    a_sleep_frame_invalid: assert property (p_sleep_frame_invalid)
        else $error("sleep frame reported valid data");

    property p_auto_restart;
        @(posedge clk) disable iff (!resetn)
        cmdAuto |=> scanPos == $past(lowestCh) && mode == MODE_AUTO_SCAN;
    endproperty
    a_auto_restart: assert property (p_auto_restart)
        else $error("auto scan did not restart at lowest");

    property p_fixed_sample;
        @(posedge clk) disable iff (!resetn)
        (sampleNow && mode == MODE_FIXED_CHANNEL) |=> sampleStrobe
            && sampleChannel == $past(fixedChannel);
    endproperty
    a_fixed_sample: assert property (p_fixed_sample)
        else $error("fixed channel not sampled");

    property p_defaults_load;
        @(posedge clk) disable iff (!resetn)
        loadDefaults |-> $past(cmdDefaults);
    endproperty
    a_defaults_load: assert property (p_defaults_load)
        else $error("defaults loaded without command");
endmodule

/* verification/acmc_host_model.sv */
// Host side model that drives chip select, serial clock and command data
`timescale 1ns/1ps
module acmc_host_model
(
    input wire logic clk,
    output logic csN,
    output logic sclk,
    output logic sdi
);
    // ----------------------------------------
    // Pin state at time zero
    // ----------------------------------------
    // Serial clock stands still low outside frames
    initial
    begin
        csN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // ----------------------------------------
    // One frame: n clocks, bits sent MSB first
    // ----------------------------------------
    // Data changes with the rising edge, so it is settled at the falling edge
    task automatic send(input logic [31:0] bits, input int n);
        int i;
        @(posedge clk);
        csN <= 1'b0;
        repeat (4) @(posedge clk);
        for (i = 0; i < n; i++)
        begin
            sdi <= bits[31 - i];
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        csN <= 1'b1;
        // Released line shows the inverse, so a stale bit is never trusted
        sdi <= ~sdi;
        repeat (4) @(posedge clk);
    endtask
endmodule

/* verification/acmc_mode_ctrl_tb.sv */
// Self-checking bench for the operating-mode controller
`timescale 1ns/1ps
module acmc_mode_ctrl_tb;
    import acmc_pkg::*;
    localparam int DEEP_WAKE = 50;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] sequenceEnables = 8'h00;
    logic settingsAccessState = 1'b0;
    logic referenceSourceChoice = 1'b1;
    wire logic csN;
    wire logic sclk;
    wire logic sdi;
    acmc_mode_e mode;
    acmc_chan_t sampleChannel;
    acmc_chan_t alarmChannel;
    logic sampleStrobe, sampleAux, alarmAux, dataInvalid, referencePowerOn;
    logic corePowerOn, loadDefaults, settingsAbandon, analogReady;
    logic [7:0] channelPowerOn;
    logic [15:0] w;
    int errorCnt = 0;
    int nChecks = 0;
    int strobes = 0;
    int defaultsCnt = 0;
    int abandonCnt = 0;
    int n, s, d;

    // ----------------------------------------
    // Clock, partner and design
    // ----------------------------------------
    always #10 clk = ~clk;

    acmc_host_model host (.clk(clk), .csN(csN), .sclk(sclk), .sdi(sdi));

    acmc_mode_ctrl #(.CHANNELS(8), .DEEP_WAKE_CYCLES(DEEP_WAKE)) uut
    (
        .clk(clk), .resetn(resetn), .csN(csN), .sclk(sclk), .sdi(sdi),
        .sequenceEnables(sequenceEnables), .settingsAccessState(settingsAccessState),
        .referenceSourceChoice(referenceSourceChoice), .mode(mode),
        .sampleStrobe(sampleStrobe), .sampleChannel(sampleChannel), .sampleAux(sampleAux),
        .alarmChannel(alarmChannel), .alarmAux(alarmAux), .dataInvalid(dataInvalid),
        .referencePowerOn(referencePowerOn), .corePowerOn(corePowerOn),
        .channelPowerOn(channelPowerOn), .loadDefaults(loadDefaults),
        .settingsAbandon(settingsAbandon), .analogReady(analogReady)
    );

    // Pulses last one cycle, so they are counted rather than sampled
    always @(posedge clk)
    begin
        if (sampleStrobe === 1'b1) strobes++;
        if (loadDefaults === 1'b1) defaultsCnt++;
        if (settingsAbandon === 1'b1) abandonCnt++;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Junk after the command bits must be ignored by the receiver
    task automatic frm(input logic [31:0] bits, input int len);
        host.send(bits, len);
        repeat (10) @(posedge clk);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        errorCnt++;
        test_done;
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("mode", mode, MODE_IDLE);
        chk("dataInvalid", dataInvalid, 1);
        for (n = 0; n < 9; n++)
        begin
            w = (n < 8) ? 16'hC000 + 16'(n) * 16'h0400 : 16'hE000;
            frm({w, 16'hFFFF}, 32);
            chk("mode", mode, MODE_FIXED_CHANNEL);
            s = strobes;
            frm(32'h0, 32);
            chk("mode", mode, MODE_FIXED_CHANNEL);
            chk("sampleChannel", sampleChannel, (n < 8) ? n : 0);
            chk("sampleAux", sampleAux, n == 8);
            chk("strobes", strobes, s + 1);
            chk("alarmAux", alarmAux, n == 8);
            chk("dataInvalid", dataInvalid, 0);
        end
        sequenceEnables <= 8'h25;
        frm({16'hA000, 16'hFFFF}, 32);
        chk("mode", mode, MODE_AUTO_SCAN);
        chk("channelPowerOn", channelPowerOn, 8'h25);
        for (n = 0; n < 4; n++)
        begin
            frm(32'h0, 32);
            chk("sampleChannel", sampleChannel, (n == 1) ? 2 : (n == 2) ? 5 : 0);
        end
        frm({16'hA000, 16'h0}, 32);
        frm(32'h0, 32);
        chk("sampleChannel", sampleChannel, 0);
        frm({16'hCC00, 16'h0}, 32);
        frm(32'h0, 32);
        frm({16'hC800, 16'h0}, 10);
        chk("mode", mode, MODE_INVALID);
        chk("dataInvalid", dataInvalid, 1);
        chk("alarmChannel", alarmChannel, 3);
        frm({16'h8200, 16'h0}, 32);
        chk("mode", mode, MODE_LIGHT_SLEEP);
        chk("corePowerOn", corePowerOn, 0);
        chk("referencePowerOn", referencePowerOn, 1);
        s = strobes;
        frm(32'h0, 32);
        chk("mode", mode, MODE_LIGHT_SLEEP);
        chk("dataInvalid", dataInvalid, 1);
        chk("strobes", strobes, s);
        frm({16'hC400, 16'h0}, 32);
        chk("mode", mode, MODE_FIXED_CHANNEL);
        chk("analogReady", analogReady, 0);
        // Chip select held high through the wake time
        repeat (1000) @(posedge clk);
        chk("analogReady", analogReady, 1);
        frm(32'h0, 32);
        chk("sampleChannel", sampleChannel, 1);
        d = defaultsCnt;
        frm({16'h8300, 16'h0}, 32);
        chk("referencePowerOn", referencePowerOn, 0);
        chk("corePowerOn", corePowerOn, 0);
        frm(32'h0, 32);
        chk("mode", mode, MODE_DEEP_SLEEP);
        referenceSourceChoice <= 1'b0;
        frm({16'hD000, 16'h0}, 32);
        chk("analogReady", analogReady, 0);
        repeat (DEEP_WAKE) @(posedge clk);
        chk("analogReady", analogReady, 1);
        chk("defaultsCnt", defaultsCnt, d);
        frm({16'h8500, 16'h0}, 32);
        chk("mode", mode, MODE_DEFAULTS);
        chk("defaultsCnt", defaultsCnt, d + 1);
        frm({16'hC000, 16'h0}, 32);
        settingsAccessState <= 1'b1;
        frm(32'h0, 32);
        chk("mode", mode, MODE_IDLE);
        chk("abandonCnt", abandonCnt, 1);
        settingsAccessState <= 1'b0;
        test_done;
    end
endmodule
